// file: hdl/dsa_logger.sv
// diagnostic logger: indicator encoder, system runtime and eight-entry alarm buffer
// assumes inputs synchronous to core_clk and an apb master for software access
//
// How it works
// - ready lamp orange after power-up until state encoding starts on red or green
// - ready steady green without fault, slow green in commissioning or factory reset
// - any fault flashes ready red fast regardless of the bus-fault lamp
// - firmware update holds ready steady red, bus-fault yellow at varying rate
// - waiting for power cycle after update flashes ready and bus-fault red slowly
// - bad memory card or failed update flashes ready and bus-fault red fast
// - safety lamp steady, slow or rapid yellow for enabled, active, faulted
// - link lamp steady green when ethernet ok, slow during naming, else off
// - serial fieldbus keeps bus-fault lamp off while data exchange is active
// - serial bus slow red without process data, fast red without connection
// - on serial bus a monitoring setting of zero keeps the bus-fault lamp dark
// - token bus lamp steady green on data exchange, fast red without it; off with no bus selected
// - token bus slow red on config fault, fast red on bus errors
// - runtime counts from power-up, software cannot reset it
// - millisecond part wraps at 86,400,000 and bumps the day part
// - each alarm takes current runtime days and milliseconds as timestamps
// - alarms need no acknowledge and clear themselves when the cause goes
// - status word bit 7 is set while any alarm is present
// - store code, fixed and float value and received days and milliseconds
// - a clearing alarm gets removal times and stays in the buffer
// - each alarm goes to the next entry and bumps the occurrence counter
// - eight entries; ninth alarm with none cleared overwrites next-to-last entry
// - writing zero to the occurrence counter drops cleared entries from the buffer
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dsa_logger
    import dsa_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = CYC_PER_MS,
    parameter int unsigned MS_PER_DAY_P  = MS_PER_DAY,
    parameter int unsigned SLOW_HALF_P   = SLOW_HALF_MS,
    parameter int unsigned FAST_HALF_P   = FAST_HALF_MS
)
(
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire dsa_state_in_s stateIn,
    input  wire dsa_alarm_in_s alarmIn,
    output dsa_led_s           ledOut,
    output logic      [15:0]   driveStatusWordOne
);

    // all block state in one record
    typedef struct packed {
        dsa_buf_t    entry;
        logic [3:0]  fill;
        logic [15:0] occCnt;
        logic [2:0]  entrySel;
        logic [1:0]  busType;
        logic [15:0] monitorSetting;
        logic [31:0] msPre;
        logic [31:0] rtMs;
        logic [15:0] rtDays;
        logic [15:0] slowCnt;
        logic [15:0] fastCnt;
        logic        slowPh;
        logic        fastPh;
        dsa_led_s    led;
        logic [15:0] statusWord;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } dsa_core_s;

    dsa_core_s stateReg;
    dsa_core_s stateNext;

    // pack live alarms toward entry zero, keeping their entry index order
    function automatic dsa_buf_t squeeze(input dsa_buf_t b);
        dsa_buf_t   o;
        logic [3:0] k;
        o = '0;
        k = '0;
        for (int i = 0; i < ALARM_DEPTH; i++)
        begin
            if (b[i].used && !b[i].removed)
            begin
                o[k[2:0]] = b[i];
                k = k + 4'h1;
            end
        end
        return o;
    endfunction

    // number of entries that hold an alarm
    function automatic logic [3:0] countUsed(input dsa_buf_t b);
        logic [3:0] k;
        k = '0;
        for (int i = 0; i < ALARM_DEPTH; i++)
        begin
            if (b[i].used)
                k = k + 4'h1;
        end
        return k;
    endfunction

    // true when some entry has already cleared
    function automatic logic anyRemoved(input dsa_buf_t b);
        logic r;
        r = 1'b0;
        for (int i = 0; i < ALARM_DEPTH; i++)
        begin
            if (b[i].used && b[i].removed)
                r = 1'b1;
        end
        return r;
    endfunction

    // true while an alarm is still standing
    function automatic logic anyActive(input dsa_buf_t b);
        logic r;
        r = 1'b0;
        for (int i = 0; i < ALARM_DEPTH; i++)
        begin
            if (b[i].used && !b[i].removed)
                r = 1'b1;
        end
        return r;
    endfunction

    // next-state logic for the whole block
    always_comb
    begin
        logic       apbAccess;
        logic       apbWrite;
        logic       msTick;
        logic [2:0] slot;
        dsa_entry_s sel;
        stateNext = stateReg;
        apbAccess = psel && penable && !stateReg.pready;
        apbWrite  = psel && penable && stateReg.pready && pwrite;
        slot      = '0;
        sel       = stateReg.entry[stateReg.entrySel];
        msTick    = (stateReg.msPre == 32'(CYCLES_PER_MS - 1));

        // millisecond prescaler
        stateNext.msPre = msTick ? '0 : stateReg.msPre + 32'h1;

        // runtime free-runs from reset release, no software path touches it
        if (msTick)
        begin
            if (stateReg.rtMs == 32'(MS_PER_DAY_P - 1))
            begin
                stateNext.rtMs   = '0;
                stateNext.rtDays = stateReg.rtDays + 16'h1;
            end
            else
                stateNext.rtMs = stateReg.rtMs + 32'h1;
        end

        // flash dividers in milliseconds
        if (msTick)
        begin
            if (stateReg.slowCnt == 16'(SLOW_HALF_P - 1))
            begin
                stateNext.slowCnt = '0;
                stateNext.slowPh  = !stateReg.slowPh;
            end
            else
                stateNext.slowCnt = stateReg.slowCnt + 16'h1;
            if (stateReg.fastCnt == 16'(FAST_HALF_P - 1))
            begin
                stateNext.fastCnt = '0;
                stateNext.fastPh  = !stateReg.fastPh;
            end
            else
                stateNext.fastCnt = stateReg.fastCnt + 16'h1;
        end

        // apb register writes, taken at the edge that sees pready high
        if (apbWrite)
        begin
            unique case (paddr)
                OFS_CONFIG:
                begin
                    stateNext.busType        = pwdata[CFG_BUS_LSB +: 2];
                    stateNext.monitorSetting = pwdata[CFG_MON_LSB +: 16];
                end
                OFS_ALARM_COUNT:
                begin
                    stateNext.occCnt = pwdata[15:0];
                    if (pwdata[15:0] == 16'h0000)
                    begin
                        stateNext.entry = squeeze(stateReg.entry);
                        stateNext.fill  = countUsed(stateNext.entry);
                    end
                end
                OFS_ENTRY_SEL:
                    stateNext.entrySel = pwdata[2:0];
                default: ;
            endcase
        end

        // cause gone: stamp removal time and keep the entry, no acknowledge
        if (alarmIn.clear)
        begin
            for (int i = 0; i < ALARM_DEPTH; i++)
            begin
                if (stateNext.entry[i].used && !stateNext.entry[i].removed &&
                    stateNext.entry[i].code == alarmIn.clearCode)
                begin
                    stateNext.entry[i].removed = 1'b1;
                    stateNext.entry[i].rmDays  = stateReg.rtDays;
                    stateNext.entry[i].rmMs    = stateReg.rtMs;
                end
            end
        end

        // incoming alarm; a full buffer first sheds cleared entries
        if (alarmIn.raise)
        begin
            if (stateNext.fill == ALARM_FULL && anyRemoved(stateNext.entry))
            begin
                stateNext.entry = squeeze(stateNext.entry);
                stateNext.fill  = countUsed(stateNext.entry);
            end
            if (stateNext.fill == ALARM_FULL)
                slot = ALARM_NEXT_LAST;
            else
            begin
                slot           = stateNext.fill[2:0];
                stateNext.fill = stateNext.fill + 4'h1;
            end
            stateNext.entry[slot].used     = 1'b1;
            stateNext.entry[slot].removed  = 1'b0;
            stateNext.entry[slot].code     = alarmIn.raiseCode;
            stateNext.entry[slot].valFixed = alarmIn.raiseFixed;
            stateNext.entry[slot].valFloat = alarmIn.raiseFloat;
            stateNext.entry[slot].rxDays   = stateReg.rtDays;
            stateNext.entry[slot].rxMs     = stateReg.rtMs;
            stateNext.entry[slot].rmDays   = '0;
            stateNext.entry[slot].rmMs     = '0;
            // counting after the write lets a new alarm win over a zero write
            stateNext.occCnt = stateNext.occCnt + 16'h1;
        end

        // alarm summary bit of the first status word
        stateNext.statusWord = '0;
        stateNext.statusWord[STATUS_ALARM_BIT] = anyActive(stateNext.entry);

        // ready lamp: power-up orange first, then firmware patterns, then fault, then normal states
        stateNext.led = '0;
        if (!stateIn.powerUpDone)
        begin
            stateNext.led.readyRed   = 1'b1;
            stateNext.led.readyGreen = 1'b1;
        end
        else if (stateIn.fwUpdateRun)
            stateNext.led.readyRed = 1'b1;
        else if (stateIn.fwWaitPowerCycle)
            stateNext.led.readyRed = stateReg.slowPh;
        else if (stateIn.fwFailed || stateIn.faultPresent)
            stateNext.led.readyRed = stateReg.fastPh;
        else if (stateIn.commissioning)
            stateNext.led.readyGreen = stateReg.slowPh;
        else
            stateNext.led.readyGreen = 1'b1;

        // bus-fault lamp: dark until power-up is done
        if (!stateIn.powerUpDone)
            stateNext.led.busFaultRed = 1'b0;
        else if (stateIn.fwUpdateRun)
            // fast blink in the high slow phase, dark in the low one, gives the varying rate
            stateNext.led.busFaultYellow = stateReg.slowPh ? stateReg.fastPh
                                                           : stateReg.slowPh;
        else if (stateIn.fwWaitPowerCycle)
            stateNext.led.busFaultRed = stateReg.slowPh;
        else if (stateIn.fwFailed)
            stateNext.led.busFaultRed = stateReg.fastPh;
        else if (stateReg.busType == BUS_SERIAL)
        begin
            if (stateReg.monitorSetting == 16'h0000)
                stateNext.led.busFaultRed = 1'b0;
            else if (stateIn.serialDataActive)
                stateNext.led.busFaultRed = 1'b0;
            else if (stateIn.serialBusActive)
                stateNext.led.busFaultRed = stateReg.slowPh;
            else
                stateNext.led.busFaultRed = stateReg.fastPh;
        end
        else if (stateReg.busType == BUS_TOKEN)
        begin
            if (stateIn.tokenCfgFault)
                stateNext.led.busFaultRed = stateReg.slowPh;
            else if (stateIn.tokenBusError)
                stateNext.led.busFaultRed = stateReg.fastPh;
            else if (stateIn.tokenDataExchange)
                stateNext.led.busFaultGreen = 1'b1;
            else
                stateNext.led.busFaultRed = stateReg.fastPh;
        end
        else
            stateNext.led.busFaultRed = 1'b0;

        // safety and link lamps dark until power-up
        if (stateIn.powerUpDone)
        begin
            if (stateIn.safetyFault)
                stateNext.led.safetyYellow = stateReg.fastPh;
            else if (stateIn.safetyActive)
                stateNext.led.safetyYellow = stateReg.slowPh;
            else
                stateNext.led.safetyYellow = stateIn.safetyEnabled;
            if (stateIn.ethNaming)
                stateNext.led.linkGreen = stateReg.slowPh;
            else
                stateNext.led.linkGreen = stateIn.ethLinkOk;
        end

        // apb answer: ready one cycle into the access phase, then released
        stateNext.pready  = apbAccess;
        stateNext.pslverr = 1'b0;
        stateNext.prdata  = '0;
        if (apbAccess)
        begin
            unique case (paddr)
                OFS_CONFIG:
                begin
                    stateNext.prdata[CFG_BUS_LSB +: 2]  = stateReg.busType;
                    stateNext.prdata[CFG_MON_LSB +: 16] = stateReg.monitorSetting;
                end
                OFS_STATUS:
                begin
                    stateNext.prdata[15:0]  = stateReg.statusWord;
                    stateNext.prdata[19:16] = stateReg.fill;
                end
                OFS_RUNTIME_MS:   stateNext.prdata = stateReg.rtMs;
                OFS_RUNTIME_DAYS: stateNext.prdata[15:0] = stateReg.rtDays;
                OFS_ALARM_COUNT:  stateNext.prdata[15:0] = stateReg.occCnt;
                OFS_ENTRY_SEL:    stateNext.prdata[2:0] = stateReg.entrySel;
                OFS_ENTRY_CODE:   stateNext.prdata[15:0] = sel.code;
                OFS_ENTRY_FIXED:  stateNext.prdata = sel.valFixed;
                OFS_ENTRY_FLOAT:  stateNext.prdata = sel.valFloat;
                OFS_ENTRY_RX_D:   stateNext.prdata[15:0] = sel.rxDays;
                OFS_ENTRY_RX_MS:  stateNext.prdata = sel.rxMs;
                OFS_ENTRY_RM_D:   stateNext.prdata[15:0] = sel.rmDays;
                OFS_ENTRY_RM_MS:  stateNext.prdata = sel.rmMs;
                OFS_ENTRY_FLAGS:  stateNext.prdata[1:0] = {sel.removed, sel.used};
                // unmapped offsets answer with an error
                default:          stateNext.pslverr = 1'b1;
            endcase
        end
    end

    // single state register, constants only under reset
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stateReg                <= '0;
            stateReg.monitorSetting <= MON_RESET;
        end
        else
            stateReg <= stateNext;
    end

    // outputs straight from the state register
    assign prdata             = stateReg.prdata;
    assign pready             = stateReg.pready;
    assign pslverr            = stateReg.pslverr;
    assign ledOut             = stateReg.led;
    assign driveStatusWordOne = stateReg.statusWord;

endmodule

`default_nettype wire

// file: hdl/dsa_pkg.sv
// package of the diagnostic status and alarm logger
// assumes a 125 MHz core clock and a 32-bit apb register bus
package dsa_pkg;

    // clock and time base
    localparam int unsigned CLK_PERIOD_PS   = 8000;
    localparam int unsigned MS_TIME_PS      = 1000000000;
    localparam int unsigned CYC_PER_MS      = MS_TIME_PS / CLK_PERIOD_PS;
    localparam int unsigned MS_PER_DAY      = 86400000;
    localparam int unsigned SLOW_HALF_MS    = 500;
    localparam int unsigned FAST_HALF_MS    = 100;

    // alarm buffer shape
    localparam int unsigned ALARM_DEPTH     = 8;
    localparam logic [3:0]  ALARM_FULL      = 4'h8;
    localparam logic [2:0]  ALARM_NEXT_LAST = 3'h6;
    localparam int unsigned STATUS_ALARM_BIT = 7;

    // register byte offsets
    localparam logic [7:0] OFS_CONFIG       = 8'h00;
    localparam logic [7:0] OFS_STATUS       = 8'h04;
    localparam logic [7:0] OFS_RUNTIME_MS   = 8'h08;
    localparam logic [7:0] OFS_RUNTIME_DAYS = 8'h0C;
    localparam logic [7:0] OFS_ALARM_COUNT  = 8'h10;
    localparam logic [7:0] OFS_ENTRY_SEL    = 8'h14;
    localparam logic [7:0] OFS_ENTRY_CODE   = 8'h18;
    localparam logic [7:0] OFS_ENTRY_FIXED  = 8'h1C;
    localparam logic [7:0] OFS_ENTRY_FLOAT  = 8'h20;
    localparam logic [7:0] OFS_ENTRY_RX_D   = 8'h24;
    localparam logic [7:0] OFS_ENTRY_RX_MS  = 8'h28;
    localparam logic [7:0] OFS_ENTRY_RM_D   = 8'h2C;
    localparam logic [7:0] OFS_ENTRY_RM_MS  = 8'h30;
    localparam logic [7:0] OFS_ENTRY_FLAGS  = 8'h34;

    // config register fields and reset values
    localparam int unsigned CFG_BUS_LSB     = 0;
    localparam int unsigned CFG_MON_LSB     = 16;
    localparam logic [15:0] MON_RESET       = 16'h0064;

    // fieldbus selection
    typedef enum logic [1:0] {
        BUS_NONE   = 2'b00,
        BUS_SERIAL = 2'b01,
        BUS_TOKEN  = 2'b10
    } dsa_bus_e;

    // indicator lamp drive, orange is red plus green
    typedef struct packed {
        logic readyRed;
        logic readyGreen;
        logic busFaultRed;
        logic busFaultGreen;
        logic busFaultYellow;
        logic safetyYellow;
        logic linkGreen;
    } dsa_led_s;

    // one alarm buffer entry
    typedef struct packed {
        logic        used;
        logic        removed;
        logic [15:0] code;
        logic [31:0] valFixed;
        logic [31:0] valFloat;
        logic [15:0] rxDays;
        logic [31:0] rxMs;
        logic [15:0] rmDays;
        logic [31:0] rmMs;
    } dsa_entry_s;

    typedef dsa_entry_s [ALARM_DEPTH-1:0] dsa_buf_t;

    // inverter, safety and communication state inputs
    typedef struct packed {
        logic powerUpDone;
        logic faultPresent;
        logic commissioning;
        logic fwUpdateRun;
        logic fwWaitPowerCycle;
        logic fwFailed;
        logic safetyEnabled;
        logic safetyActive;
        logic safetyFault;
        logic ethLinkOk;
        logic ethNaming;
        logic serialDataActive;
        logic serialBusActive;
        logic tokenDataExchange;
        logic tokenCfgFault;
        logic tokenBusError;
    } dsa_state_in_s;

    // alarm event inputs
    typedef struct packed {
        logic        raise;
        logic [15:0] raiseCode;
        logic [31:0] raiseFixed;
        logic [31:0] raiseFloat;
        logic        clear;
        logic [15:0] clearCode;
    } dsa_alarm_in_s;

endpackage

// file: testbench/dsa_lamp_panel.sv
// lamp panel model: counts on/off changes of each indicator lamp
// assumes lamp levels change only at core_clk edges
`timescale 1ns/1ps
`default_nettype none

module dsa_lamp_panel
    import dsa_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      clrCnt,
    input  wire dsa_led_s  ledOut,
    output logic [6:0][7:0] togCnt
);
    logic [6:0] lastLed;

    // a change counts one cycle late; clear restarts every count at once
    always_ff @(posedge core_clk)
    begin
        lastLed <= ledOut;
        for (int i = 0; i < 7; i++)
            togCnt[i] <= clrCnt ? 8'h00 : togCnt[i] + {7'h00, ledOut[i] ^ lastLed[i]};
    end
endmodule
`default_nettype wire

// file: testbench/dsa_logger_asserts.sv
// checker for the logger ports: apb answer timing, alarm status word, lamp encoding
// assumes binding to every dsa_logger instance, inputs synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none

module dsa_logger_asserts
    import dsa_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          rst_n,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic [7:0]    paddr,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire dsa_state_in_s stateIn,
    input wire dsa_alarm_in_s alarmIn,
    input wire dsa_led_s      ledOut,
    input wire logic [15:0]   driveStatusWordOne
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // bus answer: one pulse, exactly one cycle into the access phase
    a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not one pulse");
    a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h37
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("data outside answer");
    // alarm status bit follows a raise, other status bits stay clear
    a_alarm_bit: assert property (alarmIn.raise |=> driveStatusWordOne[7])
        else $error("alarm bit not set");
    a_status_spare: assert property (driveStatusWordOne[15:8] == 8'h00
        && driveStatusWordOne[6:0] == 7'h00) else $error("spare status bits set");
    // lamp encoding, one cycle from state to lamp
    a_boot_orange: assert property (rst_n && !stateIn.powerUpDone
        |=> ledOut.readyRed && ledOut.readyGreen) else $error("ready not orange at boot");
    a_fw_red: assert property (stateIn.powerUpDone && stateIn.fwUpdateRun
        |=> ledOut.readyRed && !ledOut.readyGreen) else $error("ready not red in update");
    a_ready_green: assert property (stateIn.powerUpDone && !stateIn.faultPresent
        && !stateIn.commissioning && !stateIn.fwUpdateRun && !stateIn.fwWaitPowerCycle
        && !stateIn.fwFailed |=> ledOut.readyGreen && !ledOut.readyRed)
        else $error("ready not steady green");
    a_link_off: assert property (!stateIn.ethLinkOk && !stateIn.ethNaming
        |=> !ledOut.linkGreen) else $error("link lamp lit");
    a_safe_steady: assert property (stateIn.powerUpDone && stateIn.safetyEnabled
        && !stateIn.safetyActive && !stateIn.safetyFault |=> ledOut.safetyYellow)
        else $error("safety lamp not steady");
endmodule

bind dsa_logger dsa_logger_asserts u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stateIn(stateIn),
    .alarmIn(alarmIn), .ledOut(ledOut), .driveStatusWordOne(driveStatusWordOne)
);
`default_nettype wire

// file: testbench/tb.sv
// bench for the diagnostic logger: apb tasks, queue model of the alarm buffer, lamp rates
// assumes a shortened time base: 4 cycles a ms, 10 ms a day, flash halves 4 and 2 ms
`timescale 1ns/1ps
`default_nettype none

module tb;
    import dsa_pkg::*;
    typedef struct {logic [15:0] c; logic [31:0] x; logic [31:0] f; logic rm;} dsa_tb_ent_s;
    logic            core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic            pwrite = 1'b0, clrCnt = 1'b0, pready, pslverr, se;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0, prdata, rd;
    dsa_state_in_s   stateIn = '0;
    dsa_alarm_in_s   alarmIn = '0;
    dsa_led_s        ledOut;
    logic [15:0]     driveStatusWordOne;
    logic [6:0][7:0] togCnt;
    logic [63:0]     tab [18];
    dsa_tb_ent_s     q [$];
    int              err_total = 0, n_compared = 0, n, e;
    int unsigned     seed = 22, t0, t1;

    always #4 core_clk = ~core_clk;

    dsa_logger #(.CYCLES_PER_MS(4), .MS_PER_DAY_P(10), .SLOW_HALF_P(4), .FAST_HALF_P(2))
    i_dsa_logger (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stateIn(stateIn), .alarmIn(alarmIn), .ledOut(ledOut),
        .driveStatusWordOne(driveStatusWordOne));
    dsa_lamp_panel panel (.core_clk(core_clk), .clrCnt(clrCnt), .ledOut(ledOut),
        .togCnt(togCnt));

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    // one apb transfer; request held until pready is seen, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = '0);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            tick(1);
        if (k == 20)
        begin
            err_total++;
            results();
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask
    // runtime in ms; reread when a day rolls over between the two halves
    task automatic rt(output int unsigned t);
        int unsigned d;
        repeat (2)
        begin
            apb(1'b0, OFS_RUNTIME_DAYS);
            d = rd;
            apb(1'b0, OFS_RUNTIME_MS);
            t = rd;
            apb(1'b0, OFS_RUNTIME_DAYS);
            if (rd == d)
                break;
        end
        check(32'(t < 10), 32'h1);
        t = d * 10 + t;
    endtask
    task automatic raise();
        dsa_tb_ent_s x = '{16'(rnd()), rnd(), rnd(), 1'b0};
        alarmIn <= '{1'b1, x.c, x.x, x.f, 1'b0, 16'h0};
        tick(1);
        alarmIn.raise <= 1'b0;
        tick(1);
        if (q.size() == ALARM_DEPTH)
            q[ALARM_NEXT_LAST] = x;
        else
            q.push_back(x);
    endtask
    task automatic clear(input logic [15:0] c);
        alarmIn.clear <= 1'b1;
        alarmIn.clearCode <= c;
        tick(1);
        alarmIn.clear <= 1'b0;
        tick(1);
        foreach (q[k])
            if (q[k].c == c)
                q[k].rm = 1'b1;
    endtask
    task automatic entry_chk(input int i);
        apb(1'b1, OFS_ENTRY_SEL, 32'(i));
        apb(1'b0, OFS_ENTRY_CODE);
        check(rd, {16'h0, q[i].c});
        apb(1'b0, OFS_ENTRY_FIXED);
        check(rd, q[i].x);
        apb(1'b0, OFS_ENTRY_FLOAT);
        check(rd, q[i].f);
        apb(1'b0, OFS_ENTRY_FLAGS);
        check(rd, {30'h0, q[i].rm, 1'b1});
    endtask

    // main sequence: reset values, runtime, lamp table, alarm buffer
    initial
    begin
        tab = '{64'h00640000_A000_5_08_0, 64'h00640000_8000_5_00_1, 64'h00640000_C000_6_10_0,
            64'h00640001_9000_6_00_1, 64'h00640001_8800_4_08_0, 64'h00640002_8800_6_08_0,
            64'h00640002_8400_4_10_0, 64'h00640000_8380_1_10_0, 64'h00640000_8300_1_08_0,
            64'h00640000_8200_1_00_1, 64'h00640000_8020_0_08_0, 64'h00640000_8040_0_00_1,
            64'h00640001_8010_4_00_0, 64'h00640001_8008_4_08_0, 64'h00000001_8000_4_00_0,
            64'h00640002_8004_3_00_1, 64'h00640002_8002_4_08_0, 64'h00640002_8001_4_10_0};
        tick(5);
        rst_n <= 1'b1;
        tick(3);
        apb(1'b0, OFS_CONFIG);
        check(rd, 32'h00640000);
        apb(1'b0, 8'h40);
        check({se, rd[30:0]}, 32'h80000000);
        rt(t0);
        tick(200);
        apb(1'b1, OFS_RUNTIME_MS);
        rt(t1);
        check(32'(t1 - t0 >= 50 && t1 - t0 <= 60), 32'h1);
        // lamp table: config, state, lamp bit, changes in 128 cycles, steady level
        foreach (tab[k])
        begin
            apb(1'b1, OFS_CONFIG, tab[k][63:32]);
            stateIn <= tab[k][31:16];
            tick(3);
            clrCnt <= 1'b1;
            tick(1);
            clrCnt <= 1'b0;
            tick(128);
            n = togCnt[tab[k][15:12]];
            e = tab[k][11:4];
            check(32'(n >= e - 1 && n <= e + 1), 32'h1);
            if (e == 0)
                check(32'(ledOut[tab[k][15:12]]), 32'(tab[k][0]));
        end
        stateIn <= 16'h8000;
        rt(t0);
        raise();
        rt(t1);
        apb(1'b1, OFS_ENTRY_SEL);
        apb(1'b0, OFS_ENTRY_RX_D);
        n = rd * 10;
        apb(1'b0, OFS_ENTRY_RX_MS);
        n += rd;
        check(32'(n >= t0 && n <= t1), 32'h1);
        apb(1'b0, OFS_STATUS);
        check(rd, 32'h00010080);
        repeat (8) raise();
        for (int k = 0; k < 8; k++)
            entry_chk(k);
        apb(1'b0, OFS_ALARM_COUNT);
        check(rd, 32'h9);
        clear(q[0].c);
        entry_chk(0);
        apb(1'b0, OFS_ENTRY_RM_D);
        e = rd * 10;
        apb(1'b0, OFS_ENTRY_RM_MS);
        check(32'(e + rd > t1), 32'h1);
        apb(1'b1, OFS_ALARM_COUNT);
        for (int k = q.size() - 1; k >= 0; k--)
            if (q[k].rm)
                q.delete(k);
        apb(1'b0, OFS_STATUS);
        check(rd, {12'h0, 4'(q.size()), 16'h0080});
        foreach (q[k])
            entry_chk(k);
        foreach (q[k])
            clear(q[k].c);
        apb(1'b0, OFS_STATUS);
        check(rd, {12'h0, 4'(q.size()), 16'h0000});
        results();
    end
endmodule
`default_nettype wire
